// ==== logic/cicf_pkg.sv ====
// Purpose: Shared constants and types for the interface configuration and filter block.
// Assumes: One 10 MHz system clock, synchronous active-high reset.
// Notes: Bit-timing table values are plain defaults, to be tuned per oscillator.
`default_nettype none
package cicf_pkg;

    // ==========================================================
    // Clock and time
    localparam int CLK_PERIOD_NS = 100;
    localparam int SECOND_NS = 1_000_000_000;
    localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int PRE_W = 24;
    localparam int TS_W = 32;

    // ==========================================================
    // Frame and filter geometry
    localparam int STD_ID_W = 11;
    localparam int EXT_ID_W = 29;
    localparam int FLT_W = 28;
    localparam int HALF_W = 14;
    localparam int BYTE_W = 8;
    localparam logic [FLT_W-1:0] MASK_RST = 28'hFFFFFFF;
    localparam logic [FLT_W-1:0] CMP_RST = 28'h0000000;

    // ==========================================================
    // Rate word decoding
    localparam logic [15:0] ADV_TAG = 16'h8000;
    localparam int ADV_TAG_LSB = 16;
    localparam int BIT_TIMING_REG_ONE_LSB = 8;
    localparam logic [BYTE_W-1:0] BIT_TIMING_REG_ONE_BASIC = 8'h1C;
    localparam logic [31:0] RATE_DEFAULT = 32'h0007A120;
    localparam logic [BYTE_W-1:0] BIT_TIMING_REG_ZERO_DEFAULT = 8'h00;

    typedef enum logic [1:0] {
        CICF_SINGLE_STD,
        CICF_SINGLE_EXT,
        CICF_DUAL_STD,
        CICF_DUAL_EXT
    } cicf_fmode_e;

    // Host-side settings, latched as one word
    typedef struct packed {
        logic route_backplane;
        logic rate_10mhz;
        logic ts_relative;
        logic [31:0] rate_word;
        logic listen_only;
        logic self_rx;
        cicf_fmode_e fmode;
        logic [FLT_W-1:0] mask;
        logic [FLT_W-1:0] cmp;
    } cicf_cfg_s;

    // One received or transmitted frame
    typedef struct packed {
        logic ext;
        logic rtr;
        logic [EXT_ID_W-1:0] id;
        logic [BYTE_W-1:0] data0;
        logic [BYTE_W-1:0] data1;
    } cicf_frame_s;

endpackage
`default_nettype wire

// ==== logic/cicf_match.sv ====
// Purpose: One mask/comparator acceptance check.
// Assumes: Mask bit set means the bit is ignored.
// Notes: Pure combinational; used once per filter half.
`timescale 1ns/1ps
`default_nettype none
module cicf_match
#(
    parameter int W = 14
)
(
    input wire logic [W-1:0] value_i,
    input wire logic [W-1:0] cmp_i,
    input wire logic [W-1:0] mask_i,
    output logic match_o
);

    // ==========================================================
    // Compare
    // Every bit either masked off or equal to the comparator
    assign match_o = &(mask_i | ~(value_i ^ cmp_i));

endmodule // cicf_match
`default_nettype wire

// ==== logic/cicf_ts_timer.sv ====
// Purpose: Shared seconds timer behind both ports' timestamps.
// Assumes: SEC_CYCLES clock cycles make one second.
// Notes: Clear restarts prescaler and seconds together.
`timescale 1ns/1ps
`default_nettype none
module cicf_ts_timer
#(
    parameter int SEC_CYCLES = cicf_pkg::SEC_CYCLES
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clear_i,
    output logic [cicf_pkg::TS_W-1:0] seconds_o
);

    logic [cicf_pkg::PRE_W-1:0] pre;

    // ==========================================================
    // Prescaler and seconds count
    always_ff @(posedge clk_i)
    begin
        if (reset_i || clear_i)
        begin
            pre <= '0;
            seconds_o <= '0;
        end
        else if (pre == cicf_pkg::PRE_W'(SEC_CYCLES - 1))
        begin
            pre <= '0;
            seconds_o <= seconds_o + 1'b1; // Wraps after 2^32 s, far beyond use
        end
        else
        begin
            pre <= pre + 1'b1;
        end
    end

endmodule // cicf_ts_timer
`default_nettype wire

// ==== logic/cicf_top.sv ====
// Purpose: Configuration latch, bit timing decode, timestamping and acceptance filter of one port.
// Assumes: Frame core on the same clock reports received and sent frames as one-cycle pulses.
// Notes: Settings are only taken while the port is stopped.
`timescale 1ns/1ps
`default_nettype none
module cicf_top
#(
    parameter int SEC_CYCLES = cicf_pkg::SEC_CYCLES
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    // Host control
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic cfg_load_i,
    input wire cicf_pkg::cicf_cfg_s cfg_i,
    input wire logic [cicf_pkg::TS_W-1:0] epoch_base_i,
    output logic running_o,
    output logic cfg_refused_o,
    output cicf_pkg::cicf_cfg_s cfg_o,
    // Timebase and bit timing
    output logic timebase_10mhz_o,
    output logic [cicf_pkg::BYTE_W-1:0] bit_timing_reg_zero_o,
    output logic [cicf_pkg::BYTE_W-1:0] bit_timing_reg_one_o,
    // Shared timer with the other port
    input wire logic peer_ts_reset_i,
    output logic ts_reset_o,
    output logic [cicf_pkg::TS_W-1:0] timestamp_o,
    // Transmit side
    input wire logic tx_req_i,
    output logic tx_start_o,
    output logic tx_reject_o,
    output logic ack_enable_o,
    input wire logic tx_done_i,
    input wire cicf_pkg::cicf_frame_s tx_frame_i,
    // Error state
    input wire logic core_err_passive_i,
    output logic err_passive_o,
    output logic err_passive_warn_o,
    // Receive side
    input wire logic rx_valid_i,
    input wire cicf_pkg::cicf_frame_s rx_frame_i,
    output logic rx_valid_o,
    output cicf_pkg::cicf_frame_s rx_frame_o,
    output logic rx_self_o,
    output logic [cicf_pkg::TS_W-1:0] rx_ts_o
);

    logic running;
    cicf_pkg::cicf_cfg_s cfg;
    logic [cicf_pkg::BYTE_W-1:0] bit_timing_reg_zero;
    logic [cicf_pkg::BYTE_W-1:0] bit_timing_reg_one;
    logic rate_ok;
    logic [cicf_pkg::BYTE_W-1:0] next_bit_timing_reg_zero;
    logic [cicf_pkg::BYTE_W-1:0] next_bit_timing_reg_one;
    logic load_ok;
    logic fmt_change;
    logic timer_clear;
    logic [cicf_pkg::TS_W-1:0] seconds;
    logic [cicf_pkg::TS_W-1:0] start_mark;
    logic echo_pend;
    cicf_pkg::cicf_frame_s echo_frame;
    logic cand_valid;
    logic cand_self;
    cicf_pkg::cicf_frame_s cand;
    logic [cicf_pkg::HALF_W-1:0] vec_a;
    logic [cicf_pkg::HALF_W-1:0] vec_b;
    logic type_ok;
    logic match_a;
    logic match_b;
    logic accept;

    // ==========================================================
    // Run state
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            running <= 1'b0;
        end
        else if (stop_i)
        begin
            running <= 1'b0;
        end
        else if (start_i)
        begin
            running <= 1'b1; // Host must have set the timebase by now
        end
    end

    assign running_o = running;

    // ==========================================================
    // Rate word decoding
    // Basic rates use a table for the default timebase; a mismatch refuses the load
    always_comb
    begin
        rate_ok = 1'b1;
        next_bit_timing_reg_one = cicf_pkg::BIT_TIMING_REG_ONE_BASIC;
        next_bit_timing_reg_zero = cicf_pkg::BIT_TIMING_REG_ZERO_DEFAULT;
        if (cfg_i.rate_word[31:cicf_pkg::ADV_TAG_LSB] == cicf_pkg::ADV_TAG)
        begin
            next_bit_timing_reg_zero = cfg_i.rate_word[cicf_pkg::BYTE_W-1:0];
            next_bit_timing_reg_one = cfg_i.rate_word[cicf_pkg::BIT_TIMING_REG_ONE_LSB +: cicf_pkg::BYTE_W];
        end
        else
        begin
            case (cfg_i.rate_word)
                32'h00008235: next_bit_timing_reg_zero = 8'h3B; // 33333 bit/s
                32'h00014585: next_bit_timing_reg_zero = 8'h17; // 83333 bit/s
                32'h000186A0: next_bit_timing_reg_zero = 8'h13; // 100000 bit/s
                32'h0001E848: next_bit_timing_reg_zero = 8'h0F; // 125000 bit/s
                32'h00030D40: next_bit_timing_reg_zero = 8'h09; // 200000 bit/s
                32'h0003D090: next_bit_timing_reg_zero = 8'h07; // 250000 bit/s
                32'h00061A80: next_bit_timing_reg_zero = 8'h04; // 400000 bit/s
                32'h0007A120: next_bit_timing_reg_zero = 8'h03; // 500000 bit/s
                32'h000C3500: next_bit_timing_reg_zero = 8'h02; // 800000 bit/s
                32'h000F4240: next_bit_timing_reg_zero = 8'h01; // 1000000 bit/s
                default: rate_ok = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // Settings latch
    // Changes during traffic would corrupt frames on the wire, so they are refused
    assign load_ok = cfg_load_i && !running && rate_ok;
    assign fmt_change = load_ok && (cfg_i.ts_relative != cfg.ts_relative);

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cfg.route_backplane <= 1'b0;
            cfg.rate_10mhz <= 1'b0; // 20 MHz after reset
            cfg.ts_relative <= 1'b0; // Absolute format
            cfg.rate_word <= cicf_pkg::RATE_DEFAULT;
            cfg.listen_only <= 1'b0;
            cfg.self_rx <= 1'b0;
            cfg.fmode <= cicf_pkg::CICF_SINGLE_STD;
            cfg.mask <= cicf_pkg::MASK_RST;
            cfg.cmp <= cicf_pkg::CMP_RST;
            bit_timing_reg_zero <= cicf_pkg::BIT_TIMING_REG_ZERO_DEFAULT;
            bit_timing_reg_one <= cicf_pkg::BIT_TIMING_REG_ONE_BASIC;
        end
        else if (load_ok)
        begin
            cfg <= cfg_i;
            bit_timing_reg_zero <= next_bit_timing_reg_zero;
            bit_timing_reg_one <= next_bit_timing_reg_one;
        end
    end

    // Refusal is a registered pulse one cycle after the load strobe
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cfg_refused_o <= 1'b0;
        end
        else
        begin
            cfg_refused_o <= cfg_load_i && !load_ok;
        end
    end

    assign cfg_o = cfg;
    assign bit_timing_reg_zero_o = bit_timing_reg_zero;
    assign bit_timing_reg_one_o = bit_timing_reg_one;

    // ==========================================================
    // Timebase selection
    // Routing the backplane reference wins over the stored rate
    assign timebase_10mhz_o = cfg.rate_10mhz || cfg.route_backplane;

    // ==========================================================
    // Shared timestamp timer
    // Either port changing format clears the one timer they share
    assign timer_clear = fmt_change || peer_ts_reset_i;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ts_reset_o <= 1'b0;
        end
        else
        begin
            ts_reset_o <= fmt_change; // Tells the other port its timestamps restarted
        end
    end

    cicf_ts_timer
    #(
        .SEC_CYCLES(SEC_CYCLES)
    )
    u_timer
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clear_i(timer_clear),
        .seconds_o(seconds)
    );

    // Start mark; a clear while running also restarts the relative origin
    always_ff @(posedge clk_i)
    begin
        if (reset_i || timer_clear)
        begin
            start_mark <= '0;
        end
        else if (start_i && !running && !stop_i)
        begin
            start_mark <= seconds;
        end
    end

    // Timestamp in the chosen format
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            timestamp_o <= '0;
        end
        else if (cfg.ts_relative)
        begin
            timestamp_o <= seconds - start_mark;
        end
        else
        begin
            timestamp_o <= epoch_base_i + seconds;
        end
    end

    // ==========================================================
    // Transmit gating and error state
    assign tx_start_o = tx_req_i && running && !cfg.listen_only;
    assign ack_enable_o = running && !cfg.listen_only;
    assign err_passive_o = cfg.listen_only || core_err_passive_i;
    assign err_passive_warn_o = core_err_passive_i && !cfg.listen_only;

    // Rejection pulse for requests made in listen-only mode
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            tx_reject_o <= 1'b0;
        end
        else
        begin
            tx_reject_o <= tx_req_i && cfg.listen_only;
        end
    end

    // ==========================================================
    // Self reception echo
    // A bus frame has priority; the echo waits until a cycle with no bus frame, holding a single frame.
    // Success relies on a remote acknowledge, so tx_done_i only fires then
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            echo_pend <= 1'b0;
            echo_frame <= '0;
        end
        else if (tx_done_i && cfg.self_rx)
        begin
            echo_pend <= 1'b1;
            echo_frame <= tx_frame_i;
        end
        else if (!rx_valid_i)
        begin
            echo_pend <= 1'b0;
        end
    end

    assign cand_valid = rx_valid_i || echo_pend;
    assign cand_self = !rx_valid_i && echo_pend;
    assign cand = rx_valid_i ? rx_frame_i : echo_frame; // Echo is filtered like any frame

    // ==========================================================
    // Acceptance filter
    // Mode sets the bit map; frames of the other format are dropped
    always_comb
    begin
        vec_a = '0;
        vec_b = '0;
        type_ok = 1'b0;
        case (cfg.fmode)
            cicf_pkg::CICF_SINGLE_STD:
            begin
                type_ok = !cand.ext;
                {vec_a, vec_b} = {cand.id[cicf_pkg::STD_ID_W-1:0], cand.rtr, cand.data0, cand.data1};
            end
            cicf_pkg::CICF_SINGLE_EXT:
            begin
                type_ok = cand.ext;
                {vec_a, vec_b} = {cand.id[cicf_pkg::EXT_ID_W-1 -: cicf_pkg::FLT_W-1], cand.rtr};
            end
            cicf_pkg::CICF_DUAL_STD:
            begin
                type_ok = !cand.ext;
                vec_a = {cand.id[cicf_pkg::STD_ID_W-1:0], cand.rtr,
                         cand.data0[cicf_pkg::BYTE_W-1 -: cicf_pkg::HALF_W-cicf_pkg::STD_ID_W-1]};
                vec_b = vec_a;
            end
            default:
            begin
                type_ok = cand.ext;
                vec_a = cand.id[cicf_pkg::EXT_ID_W-1 -: cicf_pkg::HALF_W];
                vec_b = vec_a;
            end
        endcase
    end

    // Two halves of the mask and comparator, one check each
    cicf_match
    #(
        .W(cicf_pkg::HALF_W)
    )
    u_match_a
    (
        .value_i(vec_a),
        .cmp_i(cfg.cmp[cicf_pkg::FLT_W-1 -: cicf_pkg::HALF_W]),
        .mask_i(cfg.mask[cicf_pkg::FLT_W-1 -: cicf_pkg::HALF_W]),
        .match_o(match_a)
    );

    cicf_match
    #(
        .W(cicf_pkg::HALF_W)
    )
    u_match_b
    (
        .value_i(vec_b),
        .cmp_i(cfg.cmp[cicf_pkg::HALF_W-1:0]),
        .mask_i(cfg.mask[cicf_pkg::HALF_W-1:0]),
        .match_o(match_b)
    );

    // Single modes need both halves, dual modes either filter
    always_comb
    begin
        if (cfg.fmode == cicf_pkg::CICF_DUAL_STD || cfg.fmode == cicf_pkg::CICF_DUAL_EXT)
        begin
            accept = type_ok && (match_a || match_b);
        end
        else
        begin
            accept = type_ok && match_a && match_b;
        end
    end

    // ==========================================================
    // Receive delivery
    // Nothing rejected ever leaves here, so no consumer can see it
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            rx_valid_o <= 1'b0;
            rx_self_o <= 1'b0;
            rx_frame_o <= '0;
            rx_ts_o <= '0;
        end
        else
        begin
            rx_valid_o <= cand_valid && accept && running;
            if (cand_valid && accept && running)
            begin
                rx_self_o <= cand_self;
                rx_frame_o <= cand;
                rx_ts_o <= timestamp_o;
            end
        end
    end

endmodule // cicf_top
`default_nettype wire

// ==== verif/cicf_top_asserts.sv ====
// Purpose: Port checks for cicf_top.
// Assumes: One clock, synchronous active-high reset.
// Notes: Attached to every cicf_top by the bind below.
`timescale 1ns/1ps
`default_nettype none
module cicf_top_asserts
#(
    parameter int SEC_CYCLES = 10
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic cfg_load_i,
    input wire cicf_pkg::cicf_cfg_s cfg_i,
    input wire logic running_o,
    input wire logic cfg_refused_o,
    input wire cicf_pkg::cicf_cfg_s cfg_o,
    input wire logic timebase_10mhz_o,
    input wire logic [cicf_pkg::BYTE_W-1:0] bit_timing_reg_zero_o,
    input wire logic [cicf_pkg::BYTE_W-1:0] bit_timing_reg_one_o,
    input wire logic ts_reset_o,
    input wire logic tx_req_i,
    input wire logic tx_start_o,
    input wire logic tx_reject_o,
    input wire logic ack_enable_o,
    input wire logic core_err_passive_i,
    input wire logic err_passive_o,
    input wire logic err_passive_warn_o,
    input wire logic rx_valid_o
);
    // ==========================================================
    // Helpers
    logic [31:0] last_word;
    // Last rate word offered, so the byte split is checked without $past on a field
    always_ff @(posedge clk_i)
    begin
        last_word <= cfg_i.rate_word;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // ==========================================================
    // Properties
    property p_tb; timebase_10mhz_o == (cfg_o.rate_10mhz | cfg_o.route_backplane); endproperty
    a_tb: assert property (p_tb) else $error("timebase select wrong");
    property p_adv; cfg_load_i && !running_o && cfg_i.rate_word[31:16] == cicf_pkg::ADV_TAG
        |=> bit_timing_reg_zero_o == last_word[7:0] && bit_timing_reg_one_o == last_word[15:8]; endproperty
    a_adv: assert property (p_adv) else $error("advanced rate split wrong");
    property p_frz; cfg_load_i && running_o |=> $stable(cfg_o) && cfg_refused_o; endproperty
    a_frz: assert property (p_frz) else $error("load taken while running");
    property p_tsr; cfg_load_i && !running_o && cfg_i.rate_word == cfg_o.rate_word
        && cfg_i.ts_relative != cfg_o.ts_relative |=> ts_reset_o; endproperty
    a_tsr: assert property (p_tsr) else $error("format change kept timer");
    property p_txs; tx_start_o == (tx_req_i && running_o && !cfg_o.listen_only); endproperty
    a_txs: assert property (p_txs) else $error("transmit start wrong");
    property p_ack; ack_enable_o == (running_o && !cfg_o.listen_only); endproperty
    a_ack: assert property (p_ack) else $error("acknowledge enable wrong");
    property p_rej; tx_req_i && running_o && cfg_o.listen_only |=> tx_reject_o; endproperty
    a_rej: assert property (p_rej) else $error("no reject in listen mode");
    property p_err; err_passive_o == (cfg_o.listen_only || core_err_passive_i)
        && err_passive_warn_o == (core_err_passive_i && !cfg_o.listen_only); endproperty
    a_err: assert property (p_err) else $error("error passive wrong");
    property p_stop; !running_o |=> !rx_valid_o; endproperty
    a_stop: assert property (p_stop) else $error("frame shown while stopped");
    property p_dflt; $fell(reset_i) |-> cfg_o.mask == cicf_pkg::MASK_RST && cfg_o.cmp == cicf_pkg::CMP_RST
        && cfg_o.fmode == cicf_pkg::CICF_SINGLE_STD && !timebase_10mhz_o; endproperty
    a_dflt: assert property (p_dflt) else $error("reset settings wrong");
endmodule // cicf_top_asserts
bind cicf_top cicf_top_asserts #(.SEC_CYCLES(SEC_CYCLES)) cicf_top_asserts_inst (.*);
`default_nettype wire

// ==== verif/cicf_can_node.sv ====
// Purpose: Remote bus node facing cicf_top.
// Assumes: Frames pass as one-cycle pulses.
// Notes: Acknowledges only a transmit that really started.
`timescale 1ns/1ps
`default_nettype none
module cicf_can_node
(
    input wire logic clk_i,
    input wire logic tx_start_i,
    output logic rx_valid_o,
    output cicf_pkg::cicf_frame_s rx_frame_o,
    output logic tx_done_o,
    output cicf_pkg::cicf_frame_s tx_frame_o
);
    // Idle lines
    initial
    begin
        rx_valid_o = 1'b0;
        tx_done_o = 1'b0;
        rx_frame_o = '0;
        tx_frame_o = '0;
    end
    // One bus frame; afterwards the lines show the inverse so stale data never matches
    task automatic send(input cicf_pkg::cicf_frame_s f);
        @(posedge clk_i);
        #1;
        rx_valid_o = 1'b1;
        rx_frame_o = f;
        @(posedge clk_i);
        #1;
        rx_valid_o = 1'b0;
        rx_frame_o = ~f;
    endtask
    // Acknowledge a started transmit after dly + 1 clock edges
    task automatic ack(input cicf_pkg::cicf_frame_s f, input int dly);
        if (tx_start_i !== 1'b1)
            return;
        repeat (dly + 1) @(posedge clk_i);
        #1;
        tx_done_o = 1'b1;
        tx_frame_o = f;
        @(posedge clk_i);
        #1;
        tx_done_o = 1'b0;
        tx_frame_o = ~f;
    endtask
endmodule // cicf_can_node
`default_nettype wire

// ==== verif/cicf_top_test.sv ====
// Purpose: Self-checking bench for cicf_top.
// Assumes: Short second of SECS cycles.
// Notes: Received frames are checked against a queue of expected ones.
`timescale 1ns/1ps
`default_nettype none
module cicf_top_test;
    localparam int SECS = 10;
    logic clk_i, reset_i, start_i, stop_i, cfg_load_i, peer_ts_reset_i, tx_req_i, core_err_passive_i;
    logic running_o, cfg_refused_o, timebase_10mhz_o, ts_reset_o, tx_start_o, tx_reject_o, ack_enable_o;
    logic tx_done_i, err_passive_o, err_passive_warn_o, rx_valid_i, rx_valid_o, rx_self_o;
    logic [7:0] bit_timing_reg_zero_o, bit_timing_reg_one_o;
    logic [31:0] epoch_base_i, timestamp_o, rx_ts_o;
    cicf_pkg::cicf_cfg_s cfg_i, cfg_o, c, dc;
    cicf_pkg::cicf_frame_s tx_frame_i, rx_frame_i, rx_frame_o, f;
    logic [47:0] exp_q[$];
    int fail_count = 0;
    int checks_done = 0;
    int rate_tab[10] = '{33333, 83333, 100000, 125000, 200000, 250000, 400000, 500000, 800000, 1000000};
    logic [7:0] b0_tab[10] = '{8'h3B, 8'h17, 8'h13, 8'h0F, 8'h09, 8'h07, 8'h04, 8'h03, 8'h02, 8'h01};

    cicf_top #(.SEC_CYCLES(SECS)) cicf_top_inst (.*);
    cicf_can_node cicf_can_node_inst (.clk_i(clk_i), .tx_start_i(tx_start_o), .rx_valid_o(rx_valid_i),
        .rx_frame_o(rx_frame_i), .tx_done_o(tx_done_i), .tx_frame_o(tx_frame_i));

    // ==========================================================
    // Tasks
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk_val(input string n, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // One-cycle strobe; the leading tick keeps two strobes from meeting in one time step
    task automatic pulse(ref logic s);
        tick();
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask
    task automatic load(input cicf_pkg::cicf_cfg_s v);
        cfg_i = v;
        pulse(cfg_load_i);
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Reference acceptance: wrong id format never passes, dual modes pass on either half
    function automatic bit hit(input cicf_pkg::cicf_cfg_s v, input cicf_pkg::cicf_frame_s x);
        logic [27:0] d;
        case (v.fmode)
            cicf_pkg::CICF_SINGLE_STD: d = {x.id[10:0], x.rtr, x.data0, x.data1};
            cicf_pkg::CICF_SINGLE_EXT: d = {x.id[28:2], x.rtr};
            cicf_pkg::CICF_DUAL_STD: d = {2{x.id[10:0], x.rtr, x.data0[7:6]}};
            default: d = {2{x.id[28:15]}};
        endcase
        d = (d ^ v.cmp) & ~v.mask;
        if (x.ext != v.fmode[0])
            return 1'b0;
        if (v.fmode[1])
            return d[27:14] == 14'h0000 || d[13:0] == 14'h0000;
        return d == 28'h0000000;
    endfunction

    // ==========================================================
    // Clock, watchdog and receive monitor
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial
    begin
        #1_000_000;
        fail_count++;
        end_of_test();
    end
    // Sampled mid-cycle so the registered pulse has settled
    always @(negedge clk_i)
    begin
        if (rx_valid_o === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk_val("rx_extra", 64'h0, 64'h1);
            else
                chk_val("rx_frame", 64'(exp_q.pop_front()), {rx_self_o, rx_frame_o});
        end
    end

    // ==========================================================
    // Scenarios
    initial
    begin
        void'($urandom(8));
        {reset_i, start_i, stop_i, cfg_load_i, peer_ts_reset_i, tx_req_i, core_err_passive_i} = 7'h40;
        cfg_i = '0;
        epoch_base_i = $urandom;
        tick(16);
        reset_i = 1'b0;
        tick();
        dc = cfg_o;
        chk_val("self_rx", 64'h0, cfg_o.self_rx);
        chk_val("ts_abs", epoch_base_i, timestamp_o);
        foreach (rate_tab[i])
        begin
            c = dc;
            c.rate_word = rate_tab[i];
            load(c);
            chk_val("bit_timing_reg_zero", b0_tab[i], bit_timing_reg_zero_o);
            chk_val("bit_timing_reg_one", cicf_pkg::BIT_TIMING_REG_ONE_BASIC, bit_timing_reg_one_o);
        end
        c.rate_word = {cicf_pkg::ADV_TAG, 16'($urandom)};
        load(c);
        c.rate_word = 32'h00000123;
        load(c);
        chk_val("refused", 64'h1, cfg_refused_o);
        for (int k = 0; k < 4; k++)
        begin
            c = dc;
            {c.route_backplane, c.rate_10mhz} = 2'(k);
            load(c); // Timebase set while stopped, before any start
            chk_val("tb_10mhz", k != 0, timebase_10mhz_o);
        end
        c = dc;
        c.ts_relative = 1'b1;
        load(c);
        chk_val("ts_reset", 64'h1, ts_reset_o);
        tick(22);
        pulse(start_i);
        tick(2);
        chk_val("ts_rel0", 64'h0, timestamp_o);
        tick(10);
        chk_val("ts_rel1", 64'h1, timestamp_o);
        c.listen_only = 1'b1;
        load(c);
        chk_val("frozen", 64'h0, cfg_o.listen_only);
        pulse(stop_i);
        load(dc);
        tick(2);
        chk_val("ts_abs0", epoch_base_i, timestamp_o);
        tick(14);
        pulse(peer_ts_reset_i);
        tick(2);
        chk_val("ts_peer", epoch_base_i, timestamp_o);
        c = dc;
        c.listen_only = 1'b1;
        load(c);
        pulse(start_i);
        core_err_passive_i = 1'b1;
        tx_req_i = 1'b1;
        #1;
        chk_val("tx_start", 64'h0, tx_start_o);
        chk_val("ack_en", 64'h0, ack_enable_o);
        chk_val("warn", 64'h2, {err_passive_o, err_passive_warn_o});
        cicf_can_node_inst.ack(f, 0);
        tick();
        chk_val("reject", 64'h1, tx_reject_o);
        tx_req_i = 1'b0;
        f = 47'({$urandom, $urandom});
        f.ext = 1'b0;
        exp_q.push_back({1'b0, f});
        cicf_can_node_inst.send(f);
        chk_val("rx_ts", epoch_base_i, rx_ts_o);
        for (int s = 1; s >= 0; s--)
        begin
            pulse(stop_i);
            c = dc;
            c.self_rx = s[0];
            load(c);
            pulse(start_i);
            tx_req_i = 1'b1;
            #1;
            chk_val("tx_on", 64'h7, {tx_start_o, ack_enable_o, err_passive_warn_o});
            f = 47'({$urandom, $urandom});
            f.ext = 1'b0;
            if (s == 1)
                exp_q.push_back({1'b1, f});
            cicf_can_node_inst.ack(f, 3 * s);
            tx_req_i = 1'b0;
            tick(3);
        end
        for (int m = 0; m < 4; m++)
        begin
            pulse(stop_i);
            c = dc;
            c.fmode = cicf_pkg::cicf_fmode_e'(m[1:0]);
            c.mask = 28'($urandom | $urandom | $urandom);
            c.cmp = 28'($urandom);
            load(c);
            pulse(start_i);
            repeat (24)
            begin
                f = 47'({$urandom, $urandom});
                if (hit(c, f))
                    exp_q.push_back({1'b0, f});
                cicf_can_node_inst.send(f);
            end
        end
        tick(4);
        chk_val("rx_left", 64'h0, exp_q.size());
        end_of_test();
    end
endmodule // cicf_top_test
`default_nettype wire
